// ===== design/fram_pkg.sv
// shared constants for the serial ferroelectric ram link
// assumes both ends and the bench compile this first
package fram_pkg;

	////////////////////////////////////////////////////////////////////////////
	// array geometry
	localparam int ADDR_W = 15;
	localparam int MEM_BYTES = 32768;
	localparam int BYTE_W = 8;

	////////////////////////////////////////////////////////////////////////////
	// command byte encodings
	localparam logic [7:0] set_write_latch_cmd = 8'h06;
	localparam logic [7:0] clear_write_latch_cmd = 8'h04;
	localparam logic [7:0] status_read_cmd = 8'h05;
	localparam logic [7:0] status_write_cmd = 8'h01;
	localparam logic [7:0] mem_read_cmd = 8'h03;
	localparam logic [7:0] mem_write_cmd = 8'h02;

	////////////////////////////////////////////////////////////////////////////
	// status byte layout and reset values
	localparam int SR_LATCH_BIT = 1;
	localparam logic [7:0] SR_WRITE_MASK = 8'h8C;
	localparam logic [7:0] SR_RESET = 8'h00;
	localparam logic LATCH_RESET = 1'b0;

	////////////////////////////////////////////////////////////////////////////
	// timing
	localparam longint CLK_SYS_HZ = 20000000;
	localparam longint SCK_MAX_HZ = 20000000;
	// least half period of the serial clock, rounded up
	localparam int SCK_HALF_MIN_CYC = int'((CLK_SYS_HZ + 2 * SCK_MAX_HZ - 1) / (2 * SCK_MAX_HZ));
	// two synchroniser stages on the returning data need two cycles of margin
	localparam int SYNC_HALF_MIN_CYC = 2;
	localparam int HOST_HALF_CYC = (SCK_HALF_MIN_CYC > SYNC_HALF_MIN_CYC) ? SCK_HALF_MIN_CYC : SYNC_HALF_MIN_CYC;

endpackage

// ===== design/spi_link_if.sv
// pin bundle between serial ram host and device
// assumes the bench joins one host and one device on it
`timescale 1ns/1ps
`default_nettype none

interface spi_link_if #(
	parameter bit JOIN_DATA = 1'b0
);
	logic cs_n;
	logic sck;
	logic hold_n;
	logic wp_n;
	logic mosi;
	logic mosi_oe;
	logic so;
	logic so_oe;
	logic si;
	logic miso;

	// wire resolution; an undriven miso reads high as if pulled up, while si follows mosi unless so drives the joined wire
	assign si = (JOIN_DATA && so_oe) ? so : mosi;
	assign miso = so_oe ? so : ((JOIN_DATA && mosi_oe) ? mosi : 1'b1);

	modport device (
		input cs_n,
		input sck,
		input hold_n,
		input wp_n,
		input si,
		output so,
		output so_oe
	);

	modport host (
		output cs_n,
		output sck,
		output hold_n,
		output wp_n,
		output mosi,
		output mosi_oe,
		input miso
	);
endinterface

`default_nettype wire

// ===== design/fram_host.sv
// host end: serial clock master issuing byte transfers
// assumes user requests in clk_sys domain; serial clock is divided from clk_sys
`timescale 1ns/1ps
`default_nettype none

module fram_host #(
	parameter bit CPOL = 1'b0,
	parameter int HALF_CYC = fram_pkg::HOST_HALF_CYC
) (
	spi_link_if.host link,
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic req_valid,
	input wire logic [7:0] req_byte,
	input wire logic req_last,
	input wire logic req_listen,
	output logic req_ready,
	output logic rx_valid,
	output logic [7:0] rx_byte,
	input wire logic hold_req,
	input wire logic protect_req
);
	// only modes 0 and 3 exist, so CPOL alone picks the mode
	if (HALF_CYC < fram_pkg::HOST_HALF_CYC || HALF_CYC > 256) begin : g_bad_half
		$error("fram_host: HALF_CYC out of range");
	end

	typedef enum logic [2:0] {st_idle, st_lead, st_low, st_high, st_next, st_trail, st_gap} host_state_type;

	host_state_type state_reg;
	logic [7:0] half_cnt_reg;
	logic [2:0] bit_cnt_reg;
	logic [7:0] sh_reg;
	logic [7:0] rx_sh_reg;
	logic last_reg;
	logic cs_n_reg;
	logic sck_reg;
	logic hold_n_reg;
	logic wp_n_reg;
	logic mosi_oe_reg;
	logic ready_reg;
	logic rx_valid_reg;
	logic [7:0] rx_byte_reg;
	logic miso_s1_reg;
	logic miso_s2_reg;
	logic tick;
	logic take;

	assign tick = (half_cnt_reg == 8'(HALF_CYC - 1));
	assign take = req_valid && ready_reg;

	////////////////////////////////////////////////////////////////////////////
	// returning data crosses in through two flops
	always_ff @(posedge clk_sys) begin
		miso_s1_reg <= link.miso;
		miso_s2_reg <= miso_s1_reg;
	end

	// half period counter restarts on every state change
	always_ff @(posedge clk_sys) begin
		if (!rst_n || take || tick) begin
			half_cnt_reg <= 8'h00;
		end else begin
			half_cnt_reg <= half_cnt_reg + 8'h01;
		end
	end

	// protect pin follows the user level
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			wp_n_reg <= 1'b1;
		end else begin
			wp_n_reg <= !protect_req;
		end
	end

	// hold moves only while the serial clock sits low
	// tick edges are skipped: there the clock may rise, and hold must not move with it
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			hold_n_reg <= 1'b1;
		end else if (!sck_reg && !tick && (state_reg == st_low || state_reg == st_next)) begin
			hold_n_reg <= !hold_req;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// frame sequencer
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			state_reg <= st_idle;
			bit_cnt_reg <= 3'h0;
			sh_reg <= 8'h00;
			rx_sh_reg <= 8'h00;
			last_reg <= 1'b0;
			cs_n_reg <= 1'b1;
			sck_reg <= CPOL;
			mosi_oe_reg <= 1'b0;
			ready_reg <= 1'b1;
			rx_valid_reg <= 1'b0;
			rx_byte_reg <= 8'h00;
		end else begin
			rx_valid_reg <= 1'b0;
			unique case (state_reg)
				st_idle, st_next: begin
					if (take) begin
						// every frame opens with a falling select edge
						cs_n_reg <= 1'b0;
						sh_reg <= req_byte; // msb goes out first
						last_reg <= req_last;
						mosi_oe_reg <= !req_listen; // frees a joined data wire
						ready_reg <= 1'b0;
						bit_cnt_reg <= 3'h0;
						state_reg <= (state_reg == st_idle && CPOL) ? st_lead : st_low;
					end
				end
				st_lead: begin
					if (tick) begin
						sck_reg <= 1'b0; // mode 3 drops the clock before the first rise
						state_reg <= st_low;
					end
				end
				st_low: begin
					// a held frame simply stops the clock low
					if (tick && hold_n_reg) begin
						sck_reg <= 1'b1;
						state_reg <= st_high;
					end
				end
				st_high: begin
					if (tick) begin
						// sample late in the high half so the synchroniser has settled
						rx_sh_reg <= {rx_sh_reg[6:0], miso_s2_reg};
						sck_reg <= 1'b0;
						sh_reg <= {sh_reg[6:0], 1'b0};
						bit_cnt_reg <= bit_cnt_reg + 3'h1;
						if (bit_cnt_reg == 3'h7) begin
							rx_valid_reg <= 1'b1;
							rx_byte_reg <= {rx_sh_reg[6:0], miso_s2_reg};
							if (!last_reg) begin
								ready_reg <= 1'b1;
								state_reg <= st_next;
							end else if (CPOL) begin
								state_reg <= st_trail;
							end else begin
								cs_n_reg <= 1'b1; // one command per select
								mosi_oe_reg <= 1'b0;
								state_reg <= st_gap;
							end
						end else begin
							state_reg <= st_low;
						end
					end
				end
				st_trail: begin
					if (tick) begin
						sck_reg <= 1'b1;
						cs_n_reg <= 1'b1;
						mosi_oe_reg <= 1'b0;
						state_reg <= st_gap;
					end
				end
				st_gap: begin
					if (tick) begin
						ready_reg <= 1'b1;
						state_reg <= st_idle;
					end
				end
			endcase
		end
	end

	assign link.cs_n = cs_n_reg;
	assign link.sck = sck_reg; // at most a quarter of the system clock rate
	assign link.hold_n = hold_n_reg;
	assign link.wp_n = wp_n_reg;
	assign link.mosi = sh_reg[7];
	assign link.mosi_oe = mosi_oe_reg;
	assign req_ready = ready_reg;
	assign rx_valid = rx_valid_reg;
	assign rx_byte = rx_byte_reg;
endmodule

`default_nettype wire

// ===== design/fram_device.sv
// device end: serial ferroelectric ram slave logic
// assumes the link clock is the host's serial clock and may stop at any time;
// clk_sys only carries the exported status into the system domain
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - deselected: idle, ignore inputs, float output
// - host opens each command with select falling
// - sample input on rise, move output on fall
// - clock any rate to 20 MHz, static
// - hold low freezes frame, ignores clock, select
// - host changes hold only while clock low
// - protect pin blocks status writes, not array
// - only modes zero-zero and one-one
// - 32768 bytes of eight bits each
// - byte commits at its last bit, no busy
// - joined data wire works, output floats otherwise
// - six command byte encodings
// - eight-bit groups, msb first both ways
// - two address bytes, top bit ignored
// - one command per select assertion
module fram_device #(
	parameter int ADDR_W = fram_pkg::ADDR_W
) (
	spi_link_if.device link,
	input wire logic clk_sys,
	input wire logic rst_n,
	output logic byte_written,
	output logic latch_state
);
	if (ADDR_W < 9 || ADDR_W > 16 || (2 ** ADDR_W) != fram_pkg::MEM_BYTES) begin : g_bad_addr
		$error("fram_device: ADDR_W does not match the array");
	end

	typedef enum logic [2:0] {ph_cmd, ph_addr_hi, ph_addr_lo, ph_data, ph_ignore} phase_type;
	typedef enum logic [2:0] {op_none, op_read, op_write, op_sread, op_swrite} op_type;

	// byte array, kept across any pause or deselect
	logic [7:0] mem [0:fram_pkg::MEM_BYTES-1];

	phase_type phase_reg;
	op_type op_reg;
	logic [2:0] bit_cnt_reg;
	logic [6:0] sh_reg;
	logic [ADDR_W-1:0] addr_reg;
	logic [7:0] tx_reg;
	logic write_ok_reg;
	logic latch_reg;
	logic [7:0] sr_reg;
	logic wp_s1_reg;
	logic wp_s2_reg;
	logic so_bit_reg;
	logic so_en_reg;
	logic wr_tgl_reg;
	logic tgl_s1_reg;
	logic tgl_s2_reg;
	logic tgl_s3_reg;
	logic lat_s1_reg;
	logic lat_s2_reg;
	logic written_reg;

	logic frame_rst;
	logic active;
	logic [7:0] byte_in;
	logic done;
	logic mem_we;
	logic sr_we;
	logic [7:0] status_byte;
	logic [ADDR_W-1:0] addr_inc;
	logic [ADDR_W-1:0] addr_full;

	////////////////////////////////////////////////////////////////////////////
	// frame qualifiers
	// select rising during hold is ignored until hold returns
	assign frame_rst = !rst_n || (link.cs_n && link.hold_n);
	assign active = !link.cs_n && link.hold_n;

	always_comb begin
		byte_in = {sh_reg, link.si}; // msb arrived first
		done = active && (bit_cnt_reg == 3'h7);
		addr_inc = addr_reg + ADDR_W'(1);
		// top address bit of the high byte is dropped
		addr_full = {addr_reg[ADDR_W-1:8], byte_in};
		mem_we = done && (phase_reg == ph_data) && (op_reg == op_write) && write_ok_reg;
		// protect pin refuses status writes only
		sr_we = done && (phase_reg == ph_data) && (op_reg == op_swrite) && write_ok_reg && wp_s2_reg;
		status_byte = (sr_reg & fram_pkg::SR_WRITE_MASK) | ({7'h00, latch_reg} << fram_pkg::SR_LATCH_BIT);
	end

	////////////////////////////////////////////////////////////////////////////
	// protect pin crosses in over two link clock flops
	// limitation: it is only seen once the serial clock has run two edges
	always_ff @(posedge link.sck or negedge rst_n) begin
		if (!rst_n) begin
			wp_s1_reg <= 1'b1;
			wp_s2_reg <= 1'b1;
		end else begin
			wp_s1_reg <= link.wp_n;
			wp_s2_reg <= wp_s1_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// receive side: input is taken on rising edges only
	// the clock is the only timing source, so pauses cost nothing
	always_ff @(posedge link.sck or posedge frame_rst) begin
		if (frame_rst) begin
			phase_reg <= ph_cmd;
			op_reg <= op_none;
			bit_cnt_reg <= 3'h0;
			sh_reg <= 7'h00;
			addr_reg <= '0;
			tx_reg <= 8'h00;
			write_ok_reg <= 1'b0;
		end else if (link.hold_n) begin // hold freezes the frame
			bit_cnt_reg <= bit_cnt_reg + 3'h1; // eight-bit groups
			sh_reg <= byte_in[6:0];
			if (done) begin
				unique case (phase_reg)
					ph_cmd: begin
						// one command per select; anything after is ignored
						phase_reg <= ph_ignore;
						write_ok_reg <= latch_reg;
						unique case (byte_in)
							fram_pkg::status_read_cmd: begin
								op_reg <= op_sread;
								tx_reg <= status_byte;
								phase_reg <= ph_data;
							end
							fram_pkg::status_write_cmd: begin
								op_reg <= op_swrite;
								phase_reg <= ph_data;
							end
							fram_pkg::mem_read_cmd: begin
								op_reg <= op_read;
								phase_reg <= ph_addr_hi;
							end
							fram_pkg::mem_write_cmd: begin
								op_reg <= op_write;
								phase_reg <= ph_addr_hi;
							end
							default: begin
								op_reg <= op_none;
							end
						endcase
					end
					ph_addr_hi: begin
						addr_reg[ADDR_W-1:8] <= byte_in[ADDR_W-9:0];
						phase_reg <= ph_addr_lo;
					end
					ph_addr_lo: begin
						addr_reg <= addr_full;
						if (op_reg == op_read) begin
							tx_reg <= mem[addr_full];
						end
						phase_reg <= ph_data;
					end
					ph_data: begin
						unique case (op_reg)
							op_read: begin
								// sequential read wraps at the array end
								addr_reg <= addr_inc;
								tx_reg <= mem[addr_inc];
							end
							op_write: begin
								addr_reg <= addr_inc;
							end
							op_sread: begin
								tx_reg <= status_byte;
							end
							default: begin
								phase_reg <= ph_ignore; // a status write takes a single byte
							end
						endcase
					end
					ph_ignore: begin
						phase_reg <= ph_ignore;
					end
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// array write on the last bit of each byte; no busy state exists
	always_ff @(posedge link.sck) begin
		if (mem_we) begin
			mem[addr_reg] <= byte_in;
		end
	end

	// write latch and status byte survive deselect
	always_ff @(posedge link.sck or negedge rst_n) begin
		if (!rst_n) begin
			latch_reg <= fram_pkg::LATCH_RESET;
			sr_reg <= fram_pkg::SR_RESET;
			wr_tgl_reg <= 1'b0;
		end else if (active) begin
			if (done && phase_reg == ph_cmd) begin
				unique case (byte_in)
					fram_pkg::set_write_latch_cmd: latch_reg <= 1'b1;
					fram_pkg::clear_write_latch_cmd: latch_reg <= 1'b0;
					// a write command uses up the latch
					fram_pkg::status_write_cmd: latch_reg <= 1'b0;
					fram_pkg::mem_write_cmd: latch_reg <= 1'b0;
					default: latch_reg <= latch_reg;
				endcase
			end
			if (sr_we) begin
				sr_reg <= byte_in & fram_pkg::SR_WRITE_MASK;
			end
			if (mem_we || sr_we) begin
				wr_tgl_reg <= !wr_tgl_reg;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// transmit side: output moves on falling edges only
	// bit index follows the receive count, so the msb is out before the first rise
	always_ff @(negedge link.sck or posedge frame_rst) begin
		if (frame_rst) begin
			so_bit_reg <= 1'b0;
			so_en_reg <= 1'b0;
		end else if (link.hold_n) begin
			so_bit_reg <= tx_reg[3'h7 - bit_cnt_reg];
			so_en_reg <= (phase_reg == ph_data) && (op_reg == op_read || op_reg == op_sread);
		end
	end

	// gated straight from the pins so the float is immediate
	assign link.so = so_bit_reg;
	assign link.so_oe = so_en_reg && link.hold_n && !link.cs_n;

	////////////////////////////////////////////////////////////////////////////
	// status export to the system clock: toggle for events, two flops for the level
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			tgl_s1_reg <= 1'b0;
			tgl_s2_reg <= 1'b0;
			tgl_s3_reg <= 1'b0;
			lat_s1_reg <= 1'b0;
			lat_s2_reg <= 1'b0;
			written_reg <= 1'b0;
		end else begin
			tgl_s1_reg <= wr_tgl_reg;
			tgl_s2_reg <= tgl_s1_reg;
			tgl_s3_reg <= tgl_s2_reg;
			lat_s1_reg <= latch_reg;
			lat_s2_reg <= lat_s1_reg;
			written_reg <= tgl_s2_reg ^ tgl_s3_reg;
		end
	end

	assign byte_written = written_reg;
	assign latch_state = lat_s2_reg;
endmodule

`default_nettype wire

// ===== tb/fram_link_checker.sv
// pin assertions on the serial ram link, sampled with the system clock
// assumes a mode zero host drives the link from clk_sys flops
`timescale 1ns/1ps
`default_nettype none

module fram_link_checker #(
	parameter bit CPOL = 1'b0
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic cs_n,
	input wire logic sck,
	input wire logic hold_n,
	input wire logic wp_n,
	input wire logic mosi,
	input wire logic mosi_oe,
	input wire logic so,
	input wire logic so_oe
);
	logic [2:0] rise_cnt_reg;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	////////////////////////////////////////////////////////////////////////////
	// clock rises in the open frame, modulo one byte
	always_ff @(posedge clk_sys) begin
		if (!rst_n || cs_n) begin
			rise_cnt_reg <= 3'h0;
		end else if ($rose(sck)) begin
			rise_cnt_reg <= rise_cnt_reg + 3'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// output gating and pin timing
	idle_float_a: assert property (cs_n |-> !so_oe)
		else $error("data output driven while deselected");
	hold_float_a: assert property (!hold_n |-> !so_oe)
		else $error("data output driven during hold");
	hold_change_a: assert property ($changed(hold_n) |-> !sck)
		else $error("hold changed with clock high");
	hold_freeze_a: assert property (!hold_n && !$past(hold_n) |-> $stable(sck))
		else $error("clock moved during hold");
	so_fall_a: assert property (so_oe && $past(so_oe) && $changed(so) |-> $fell(sck))
		else $error("data output moved off a falling clock");
	mode_idle_a: assert property ($fell(cs_n) |-> sck == CPOL)
		else $error("clock idle level wrong at select");
	// only the driving phase matters; a released line may wander
	mosi_hold_a: assert property (!cs_n && !$past(cs_n) && sck && mosi_oe |-> $stable(mosi))
		else $error("host data moved with clock high");
	byte_whole_a: assert property ($rose(cs_n) |-> rise_cnt_reg == 3'h0)
		else $error("frame closed inside a byte");

	cover property ($fell(cs_n));
	cover property ($rose(so_oe));
	cover property ($fell(hold_n));
	cover property ($fell(wp_n));
endmodule

`default_nettype wire

// ===== tb/testbench.sv
// two host and device pairs, mode zero split wires and mode three joined wire
// assumes the fram package and link interface are compiled first
`timescale 1ns/1ps
`default_nettype none

module testbench;
	typedef struct {int n; logic [31:0] d; bit lis; bit prot; logic [7:0] exp; int lat; bit wr;} row_type;
	logic clk_sys, rst_n, req_valid, req_last, req_listen, hold_req, protect_req;
	logic [7:0] req_byte;
	logic rdy [2], rxv [2], bw [2], lat [2];
	logic [7:0] rxb [2];
	int failures = 0, comparisons = 0, writes = 0;
	int bw_cnt [2] = '{0, 0};
	row_type rows [19];

	spi_link_if #(.JOIN_DATA(1'b0)) link0 ();
	spi_link_if #(.JOIN_DATA(1'b1)) link1 ();
	fram_host #(.CPOL(1'b0)) u_fram_host (.link(link0.host), .clk_sys(clk_sys), .rst_n(rst_n),
		.req_valid(req_valid), .req_byte(req_byte), .req_last(req_last), .req_listen(req_listen), .req_ready(rdy[0]),
		.rx_valid(rxv[0]), .rx_byte(rxb[0]), .hold_req(hold_req), .protect_req(protect_req));
	fram_host #(.CPOL(1'b1)) u_fram_host_b (.link(link1.host), .clk_sys(clk_sys), .rst_n(rst_n),
		.req_valid(req_valid), .req_byte(req_byte), .req_last(req_last), .req_listen(req_listen), .req_ready(rdy[1]),
		.rx_valid(rxv[1]), .rx_byte(rxb[1]), .hold_req(hold_req), .protect_req(protect_req));
	fram_device u_fram_device (.link(link0.device), .clk_sys(clk_sys), .rst_n(rst_n), .byte_written(bw[0]),
		.latch_state(lat[0]));
	fram_device u_fram_device_b (.link(link1.device), .clk_sys(clk_sys), .rst_n(rst_n), .byte_written(bw[1]),
		.latch_state(lat[1]));
	fram_link_checker #(.CPOL(1'b0)) u_fram_link_checker (.clk_sys(clk_sys), .rst_n(rst_n), .cs_n(link0.cs_n),
		.sck(link0.sck), .hold_n(link0.hold_n), .wp_n(link0.wp_n), .mosi(link0.mosi), .mosi_oe(link0.mosi_oe),
		.so(link0.so), .so_oe(link0.so_oe));

	////////////////////////////////////////////////////////////////////////////
	// clock and committed byte count per device
	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end
	// counted on the falling edge, where the pulse has settled
	always @(negedge clk_sys) begin
		for (int i = 0; i < 2; i++) if (rst_n && bw[i] === 1'b1) bw_cnt[i]++;
	end

	////////////////////////////////////////////////////////////////////////////
	// compare and report
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic end_sim();
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic give_up();
		failures++;
		$display("[FAIL] handshake expected done seen timeout");
		end_sim();
	endtask

	////////////////////////////////////////////////////////////////////////////
	// one byte on both hosts at once; both must be ready at the same edge
	task automatic xfer(input logic [7:0] b, input logic last, input logic lis, output logic [7:0] r0,
		output logic [7:0] r1);
		int k;
		logic g0, g1;
		k = 0;
		g0 = 1'b0;
		g1 = 1'b0;
		do begin @(negedge clk_sys); k++; end while (!(rdy[0] === 1'b1 && rdy[1] === 1'b1) && k < 400);
		if (k >= 400) give_up();
		@(posedge clk_sys);
		req_valid <= 1'b1;
		req_byte <= b;
		req_last <= last;
		req_listen <= lis;
		@(posedge clk_sys);
		req_valid <= 1'b0;
		k = 0;
		do begin
			@(negedge clk_sys);
			k++;
			if (rxv[0] === 1'b1) begin g0 = 1'b1; r0 = rxb[0]; end
			if (rxv[1] === 1'b1) begin g1 = 1'b1; r1 = rxb[1]; end
		end while (!(g0 && g1) && k < 400);
		if (k >= 400) give_up();
	endtask

	// one frame per row; latch settles through the sync before it is read
	task automatic run_row(input int i);
		logic [7:0] r0, r1;
		logic last;
		@(posedge clk_sys);
		protect_req <= rows[i].prot;
		for (int j = 0; j < rows[i].n; j++) begin
			last = (j == rows[i].n - 1);
			xfer(rows[i].d[31 - 8 * j -: 8], last, rows[i].lis && last, r0, r1);
		end
		if (rows[i].lis) begin
			check("rx mode0", r0, rows[i].exp);
			check("rx mode3 joined", r1, rows[i].exp);
		end
		repeat (12) @(posedge clk_sys);
		@(negedge clk_sys);
		if (rows[i].lat >= 0) begin
			check("latch mode0", {7'h00, lat[0]}, 8'(rows[i].lat));
			check("latch mode3", {7'h00, lat[1]}, 8'(rows[i].lat));
		end
		if (rows[i].wr) writes++;
	endtask

	////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		rst_n = 1'b1;
		req_valid = 1'b0;
		req_byte = 8'h00;
		req_last = 1'b0;
		req_listen = 1'b0;
		hold_req = 1'b0;
		protect_req = 1'b0;
		// bytes left aligned: count, data, listen, protect, rx, latch or -1, commit
		rows = '{'{1, 32'h06000000, 0, 0, 8'h00, 1, 0}, '{4, 32'h020010A5, 0, 0, 8'h00, 0, 1},
			'{4, 32'h03801000, 1, 0, 8'hA5, 0, 0}, '{4, 32'h0200103C, 0, 0, 8'h00, 0, 0},
			'{4, 32'h03001000, 1, 0, 8'hA5, 0, 0}, '{2, 32'h04060000, 0, 0, 8'h00, 0, 0},
			'{1, 32'h06000000, 0, 0, 8'h00, 1, 0}, '{2, 32'h05000000, 1, 0, 8'h02, 1, 0},
			'{2, 32'h01840000, 0, 1, 8'h00, -1, 0}, '{1, 32'h04000000, 0, 1, 8'h00, 0, 0},
			'{2, 32'h05000000, 1, 1, 8'h00, 0, 0}, '{1, 32'h06000000, 0, 0, 8'h00, 1, 0},
			'{2, 32'h018C0000, 0, 0, 8'h00, -1, 1}, '{1, 32'h04000000, 0, 0, 8'h00, 0, 0},
			'{2, 32'h05000000, 1, 0, 8'h8C, 0, 0}, '{1, 32'h06000000, 0, 1, 8'h00, 1, 0},
			'{4, 32'h02003077, 0, 1, 8'h00, 0, 1}, '{4, 32'h03003000, 1, 1, 8'h77, 0, 0},
			'{4, 32'hAB001000, 1, 0, 8'hFF, 0, 0}}; // unknown opcode: line floats to its pull-up
		// drop after time zero so the asynchronous resets see a clean edge
		#1 rst_n = 1'b0;
		repeat (6) @(posedge clk_sys);
		rst_n <= 1'b1;
		for (int i = 0; i < 19; i++) run_row(i);
		check("commits mode0", 8'(bw_cnt[0]), 8'(writes));
		check("commits mode3", 8'(bw_cnt[1]), 8'(writes));
		// pause inside the read data byte; the byte must survive intact
		fork
			run_row(4);
			begin
				repeat (110) @(posedge clk_sys);
				@(negedge clk_sys);
				check("so_oe read", {7'h00, link0.so_oe}, 8'h01);
				@(posedge clk_sys);
				hold_req <= 1'b1;
				repeat (30) @(posedge clk_sys);
				@(negedge clk_sys);
				check("so_oe hold", {7'h00, link0.so_oe}, 8'h00);
				check("so_oe hold joined", {7'h00, link1.so_oe}, 8'h00);
				check("hold_n", {7'h00, link0.hold_n}, 8'h00);
				@(posedge clk_sys);
				hold_req <= 1'b0;
			end
		join
		// second reset mid-run clears the latch, not the array
		run_row(0);
		@(posedge clk_sys);
		rst_n <= 1'b0;
		repeat (6) @(posedge clk_sys);
		@(negedge clk_sys);
		check("latch reset", {7'h00, lat[0]}, 8'h00);
		check("cs_n reset", {7'h00, link0.cs_n}, 8'h01);
		check("so_oe reset", {7'h00, link1.so_oe}, 8'h00);
		@(posedge clk_sys);
		rst_n <= 1'b1;
		run_row(4);
		end_sim();
	end
endmodule

`default_nettype wire
